//--- rtl/ubrg_pkg.sv
package ubrg_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] BAUD_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;

  // ==========================================================================
  // Field positions in the mode word
  // ==========================================================================
  localparam int SRC_LSB = 4;
  localparam int SYNC_BIT = 8;
  localparam int OVER_BIT = 19;

  // ==========================================================================
  // Field positions in the baud word
  // ==========================================================================
  localparam int CD_LSB = 0;
  localparam int FP_LSB = 16;

  // ==========================================================================
  // Field positions in the status word
  // ==========================================================================
  localparam int STAT_OVS_LSB = 20;
  localparam int STAT_MODEM_LSB = 24;
  localparam int STAT_RUN_BIT = 31;

  // ==========================================================================
  // Source select codes and dividers
  // ==========================================================================
  localparam logic [1:0] SRC_MCK = 2'h0;
  localparam logic [1:0] SRC_DIV = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [2:0] PRE_MAX = 3'h7;
  localparam logic [3:0] OVS16_MAX = 4'hf;
  localparam logic [3:0] OVS8_MAX = 4'h7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [15:0] CD_RST = 16'h0000;
  localparam logic [2:0] FP_RST = 3'h0;
  localparam logic [3:0] MODEM_MASK_RST = 4'hf;

  typedef struct packed {
    logic over;
    logic sync;
    logic [1:0] clock_source_select;
  } ubrg_mode_t;

  typedef struct packed {
    logic [2:0] fractional_part;
    logic [15:0] clock_divisor;
  } ubrg_brg_t;

endpackage

//--- rtl/ubrg_top.sv
module ubrg_top
  import ubrg_pkg::*;
#(
  parameter logic [3:0] MODEM_PINS = MODEM_MASK_RST
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Power manager clock gate
  input wire logic pclk_en_i,
  // Serial clock pin and modem inputs
  input wire logic sck_i,
  input wire logic [3:0] modem_i,
  // Ticks to transmitter and receiver
  output logic sample_tick_o,
  output logic baud_tick_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  ubrg_mode_t mode;
  ubrg_mode_t next_mode;
  ubrg_brg_t brg;
  ubrg_brg_t next_brg;
  logic [2:0] pre_cnt;
  logic [2:0] next_pre_cnt;
  logic sck_q;
  logic next_sck_q;
  logic [16:0] div_cnt;
  logic [16:0] next_div_cnt;
  logic [2:0] frac_acc;
  logic [2:0] next_frac_acc;
  logic [3:0] ovs_cnt;
  logic [3:0] next_ovs_cnt;
  logic [31:0] next_rdata;
  logic next_sample_tick;
  logic next_baud_tick;

  logic run;
  logic src_tick;
  logic div_tick;
  logic ovs_tick;
  logic ext_direct;
  logic frac_on;
  logic [3:0] acc_sum;
  logic [3:0] ovs_max;

  function automatic logic [31:0] mode_word(input ubrg_mode_t m);
    logic [31:0] w;
    w = '0;
    w[SRC_LSB +: 2] = m.clock_source_select;
    w[SYNC_BIT] = m.sync;
    w[OVER_BIT] = m.over;
    return w;
  endfunction

  function automatic logic [31:0] baud_word(input ubrg_brg_t b);
    logic [31:0] w;
    w = '0;
    w[CD_LSB +: 16] = b.clock_divisor;
    w[FP_LSB +: 3] = b.fractional_part;
    return w;
  endfunction

  // ==========================================================================
  // Register file
  // ==========================================================================
  always_comb
  begin
    next_mode = mode;
    next_brg = brg;
    if (wr_i && addr_i == MODE_OFS)
    begin
      next_mode.clock_source_select = wdata_i[SRC_LSB +: 2];
      next_mode.sync = wdata_i[SYNC_BIT];
      next_mode.over = wdata_i[OVER_BIT];
    end
    if (wr_i && addr_i == BAUD_OFS)
    begin
      next_brg.clock_divisor = wdata_i[CD_LSB +: 16];
      next_brg.fractional_part = wdata_i[FP_LSB +: 3];
    end
    next_rdata = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        MODE_OFS: next_rdata = mode_word(mode);
        BAUD_OFS: next_rdata = baud_word(brg);
        STAT_OFS:
        begin
          next_rdata[16:0] = div_cnt;
          next_rdata[STAT_OVS_LSB +: 4] = ovs_cnt;
          next_rdata[STAT_MODEM_LSB +: 4] = modem_i & MODEM_PINS;
          next_rdata[STAT_RUN_BIT] = run && brg.clock_divisor != 16'h0000;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      mode <= '{over: 1'b0, sync: 1'b0, clock_source_select: SRC_RST};
      brg <= '{fractional_part: FP_RST, clock_divisor: CD_RST};
      rdata_o <= '0;
    end
    else
    begin
      mode <= next_mode;
      brg <= next_brg;
      rdata_o <= next_rdata;
    end
  end

  // ==========================================================================
  // Source select and divider
  // ==========================================================================
  always_comb
  begin
    run = pclk_en_i;
    ext_direct = mode.sync && mode.clock_source_select == SRC_EXT;
    frac_on = !mode.sync && brg.fractional_part != 3'h0;
    ovs_max = mode.over ? OVS8_MAX : OVS16_MAX;
    unique case (mode.clock_source_select)
      SRC_MCK: src_tick = 1'b1;
      SRC_EXT: src_tick = sck_i && !sck_q;
      default: src_tick = pre_cnt == PRE_MAX;
    endcase
    next_pre_cnt = pre_cnt;
    next_sck_q = sck_q;
    next_div_cnt = div_cnt;
    next_frac_acc = frac_acc;
    next_ovs_cnt = ovs_cnt;
    div_tick = 1'b0;
    ovs_tick = 1'b0;
    acc_sum = {1'b0, frac_acc} + {1'b0, brg.fractional_part};
    // A stopped clock freezes every counter in place
    if (run)
    begin
      next_pre_cnt = pre_cnt + 3'h1;
      next_sck_q = sck_i;
      if (brg.clock_divisor == 16'h0000)
        next_div_cnt = '0;
      else if (src_tick)
      begin
        if (div_cnt == 17'h00000)
        begin
          div_tick = 1'b1;
          next_div_cnt = {1'b0, brg.clock_divisor} - 17'h00001 + {16'h0000, frac_on && acc_sum[3]};
          next_frac_acc = frac_on ? acc_sum[2:0] : 3'h0;
        end
        else
          next_div_cnt = div_cnt - 17'h00001;
      end
      if (!mode.sync && div_tick)
      begin
        if (ovs_cnt >= ovs_max)
        begin
          ovs_tick = 1'b1;
          next_ovs_cnt = 4'h0;
        end
        else
          next_ovs_cnt = ovs_cnt + 4'h1;
      end
    end
    next_sample_tick = run && !mode.sync && div_tick;
    if (!run)
      next_baud_tick = 1'b0;
    else if (ext_direct)
      next_baud_tick = src_tick;
    else if (mode.sync)
      next_baud_tick = div_tick;
    else
      next_baud_tick = ovs_tick;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      pre_cnt <= 3'h0;
      sck_q <= 1'b0;
      div_cnt <= '0;
      frac_acc <= 3'h0;
      ovs_cnt <= 4'h0;
      sample_tick_o <= 1'b0;
      baud_tick_o <= 1'b0;
    end
    else
    begin
      pre_cnt <= next_pre_cnt;
      sck_q <= next_sck_q;
      div_cnt <= next_div_cnt;
      frac_acc <= next_frac_acc;
      ovs_cnt <= next_ovs_cnt;
      sample_tick_o <= next_sample_tick;
      baud_tick_o <= next_baud_tick;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_fast_async;
    run && brg.clock_divisor == 16'h0001 && !frac_on && !mode.sync && mode.clock_source_select == SRC_MCK
      && div_cnt == 17'h00000;
  endsequence

  sequence s_sync_mck_bypass;
    run && brg.clock_divisor == 16'h0001 && mode.sync && mode.clock_source_select == SRC_MCK && div_cnt == 17'h00000;
  endsequence

  a_zero_divisor_silent: assert property (
    run && brg.clock_divisor == 16'h0000 && !ext_direct |=> !sample_tick_o && !baud_tick_o)
    else $error("tick produced with zero divisor");

  a_bypass_samples: assert property (s_fast_async |=> sample_tick_o)
    else $error("bypassed divider missed a sample tick");

  a_sync_passthru: assert property (s_sync_mck_bypass |=> baud_tick_o)
    else $error("sync bypass missed a bit tick");

  a_oversample_count: assert property (
    baud_tick_o && !$past(mode.sync) |-> sample_tick_o && $past(ovs_cnt) >= ($past(mode.over) ? OVS8_MAX : OVS16_MAX))
    else $error("bit tick at wrong oversample count");

  a_stop_holds: assert property (
    !pclk_en_i |=> $stable(div_cnt) && $stable(ovs_cnt) && !baud_tick_o && !sample_tick_o)
    else $error("state moved while clock stopped");

  a_cfg_write_off: assert property (
    wr_i && addr_i == BAUD_OFS && !pclk_en_i |=> brg.clock_divisor == $past(wdata_i[15:0]))
    else $error("divisor write lost while clock stopped");

  a_ext_direct_pass: assert property (
    run && ext_direct && sck_i && !sck_q |=> baud_tick_o)
    else $error("pin edge not passed straight through");

  a_divider_reload: assert property (
    run && src_tick && div_cnt == 17'h00000 && brg.clock_divisor != 16'h0000 && !frac_on
    |=> div_cnt == {1'b0, $past(brg.clock_divisor)} - 17'h00001)
    else $error("divider reloaded with wrong count");

  a_read_latency: assert property (
    rd_i && addr_i == MODE_OFS |=> rdata_o == mode_word($past(mode)))
    else $error("mode read data wrong");

  a_read_idle_zero: assert property (!rd_i |=> rdata_o == 32'h00000000)
    else $error("read data not zero outside read");

  a_sync_no_sample: assert property (
    run && mode.sync |=> !sample_tick_o)
    else $error("sample tick in synchronous mode");

  a_modem_masked: assert property (
    rd_i && addr_i == STAT_OFS |=> rdata_o[STAT_MODEM_LSB +: 4] == ($past(modem_i) & MODEM_PINS))
    else $error("absent modem pin visible in status");

  a_frac_stretch: assert property (
    run && src_tick && div_cnt == 17'h00000 && brg.clock_divisor != 16'h0000 && frac_on && acc_sum[3]
    |=> div_cnt == {1'b0, $past(brg.clock_divisor)})
    else $error("fraction carry did not stretch the period");

  a_pin_edge_only: assert property (
    run && ext_direct && !(sck_i && !sck_q) |=> !baud_tick_o)
    else $error("bit tick without a pin edge");

  a_sync_div_tick: assert property (
    run && mode.sync && !ext_direct && src_tick && div_cnt == 17'h00000 && brg.clock_divisor != 16'h0000
    |=> baud_tick_o)
    else $error("sync divider tick not passed to bit tick");

endmodule // ubrg_top

//--- bench/ubrg_sck_src.sv
// ==========================================================================
// External serial clock source
// ==========================================================================
module ubrg_sck_src #(
  parameter int HALF = 3
)
(
  // Clock and control
  input wire logic sys_clk_i,
  input wire logic run_i,
  // Serial clock pin
  output logic sck_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt = 0;

  initial sck_o = 1'b0;

  // Each phase lasts HALF master cycles, so the period stays well clear of the master clock
  always @(posedge sys_clk_i)
  begin
    if (run_i)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        sck_o <= ~sck_o;
    end
  end
endmodule // ubrg_sck_src

//--- bench/tb_ubrg_top.sv
// ==========================================================================
// Baud generator bench
// ==========================================================================
module tb_ubrg_top
  import ubrg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SCKP = 6;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, pclk_en_i = 1'b1, sck_run = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] modem_i = 4'h0;
  logic [31:0] rdata_o;
  logic sample_tick_o, baud_tick_o, sck;
  int fails = 0, checks = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  ubrg_top #(.MODEM_PINS(4'h5)) i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pclk_en_i(pclk_en_i), .sck_i(sck),
    .modem_i(modem_i), .sample_tick_o(sample_tick_o), .baud_tick_o(baud_tick_o));
  ubrg_sck_src #(.HALF(SCKP / 2)) i_sck (.sys_clk_i(sys_clk_i), .run_i(sck_run), .sck_o(sck));

  task automatic conclude();
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge sys_clk_i);
    #1 chk(rdata_o, 32'h0);
  endtask

  function automatic logic tk(bit b);
    return b ? baud_tick_o : sample_tick_o;
  endfunction

  // Skips a partial and a full period, then counts the next full one
  task automatic gap(input bit b, output int n);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(posedge sys_clk_i);
        #1 n++;
      end while (tk(b) !== 1'b1 && n < 4000);
    end
  endtask

  function automatic int expp(bit sy, logic [1:0] s, bit ov, int cd, int fp);
    int m;
    m = (s == SRC_MCK) ? 1 : (s == SRC_EXT) ? SCKP : 8;
    if (sy)
      return (s == SRC_EXT) ? SCKP : m * cd;
    return m * (8 * (2 - ov) * cd + (2 - ov) * fp);
  endfunction

  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    fails++;
    conclude();
  end

  initial
  begin
    logic [31:0] d;
    int n, e, cd, fp;
    logic [1:0] s;
    bit sy, ov;
    n = $urandom(32'h1a54bc57);
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    sck_run <= 1'b1;
    rd(MODE_OFS, d);
    chk(d, 32'h0);
    rd(BAUD_OFS, d);
    chk(d, 32'h0);
    n = 0;
    repeat (300)
    begin
      @(posedge sys_clk_i);
      #1 n += int'(sample_tick_o | baud_tick_o);
    end
    chk(n, 0);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, d);
    chk(d, 32'h0);
    @(posedge sys_clk_i);
    modem_i <= 4'($urandom);
    rd(STAT_OFS, d);
    chk(d, 32'(modem_i & 4'h5) << STAT_MODEM_LSB);
    for (int i = 0; i < 14; i++)
    begin
      sy = 1'($urandom);
      ov = 1'($urandom);
      s = 2'(i);
      cd = $urandom_range(1, 4);
      fp = $urandom_range(0, 7);
      if (i == 0)
      begin
        sy = 1'b0;
        ov = 1'b1;
        fp = 0;
        cd = 1;
      end
      if (i == 1)
      begin
        sy = 1'b1;
        s = SRC_EXT;
        cd = 0;
      end
      if (i == 4)
      begin
        sy = 1'b1;
        cd = 1;
      end
      wr(MODE_OFS, (32'(ov) << OVER_BIT) | (32'(sy) << SYNC_BIT) | (32'(s) << SRC_LSB));
      wr(BAUD_OFS, (32'(fp) << FP_LSB) | 32'(cd));
      gap(1'b1, n);
      chk(n, expp(sy, s, ov, cd, fp));
      if (!sy && fp == 0)
      begin
        gap(1'b0, n);
        chk(n, expp(1'b0, s, ov, cd, 0) / (8 * (2 - ov)));
      end
    end
    wr(MODE_OFS, 32'h1 << OVER_BIT);
    wr(BAUD_OFS, 32'h2);
    gap(1'b1, n);
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      pclk_en_i <= !(n >= 5 && n < 25);
      #1 n++;
    end while (baud_tick_o !== 1'b1 && n < 4000);
    chk(n, 36);
    @(posedge sys_clk_i);
    pclk_en_i <= 1'b0;
    e = $urandom & 32'h0007ffff;
    wr(BAUD_OFS, e);
    rd(BAUD_OFS, d);
    chk(d, e);
    @(posedge sys_clk_i);
    pclk_en_i <= 1'b1;
    conclude();
  end
endmodule // tb_ubrg_top
